// ---- gate_driver_mode_fsm.sv ----
// mode state machine of a three-phase gate driver
// Summary of operation
// - rail below falling threshold forces Shutdown.
// - Shutdown keeps only standby and logic LDOs, logic LDO low power.
// - rail above rising threshold with enable low means Sleep.
// - Sleep disables gate outputs and ignores all control inputs.
// - Sleep disables buck, pump, gate LDO; keeps standby and low-power logic LDO.
// - rail up, enable high and no fault means Operating.
// - Operating enables buck, pump, gate LDO, normal logic LDO, no standby.
// - Operating drives gate outputs from the selected control signals.
// - Fault mode reports on the fault pin and a readable status.
// - listed faults are detected and any of them enters Fault mode.
// - Shutdown goes to Sleep after start-up delay once rail rises.
// - enable high in Sleep powers up and enters Operating after wake delay.
// - enable low in Operating powers down, Sleep after sleep-entry delay.
// - control registers reset entering Sleep or Shutdown from active modes.
// - rail falling from any mode enters Shutdown after shutdown delay.
// - a fault in Operating enters Fault mode with its response.
// - further faults keep Fault mode; block disables are ANDed.
// - fault cleared and recovered returns to Operating after recovery delay.
// - enable low in Fault mode enters Sleep after recovery delay.
// - logic LDO goes low power whenever enable is low.
`timescale 1ns/100ps
module gate_driver_mode_fsm
#(
    parameter int STARTUP_DLY = gate_driver_mode_pkg::STARTUP_CYC,
    parameter int WAKE_DLY = gate_driver_mode_pkg::WAKE_CYC,
    parameter int SLEEP_DLY = gate_driver_mode_pkg::SLEEP_CYC,
    parameter int SHUTDOWN_DLY = gate_driver_mode_pkg::SHUTDOWN_CYC,
    parameter int RECOVER_DLY = gate_driver_mode_pkg::RECOVER_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic rail_por_rise_i,
    input wire logic rail_por_fall_i,
    input wire logic enable_i,
    input wire logic [gate_driver_mode_pkg::NUM_FAULTS-1:0] fault_i,
    input wire logic [gate_driver_mode_pkg::NUM_FAULTS*gate_driver_mode_pkg::NUM_BLK-1:0]
        fault_blk_dis_n_i,
    input wire logic recovery_done_i,
    input wire logic [gate_driver_mode_pkg::NUM_PHASES-1:0] high_side_ctrl_i,
    input wire logic [gate_driver_mode_pkg::NUM_PHASES-1:0] low_side_ctrl_i,
    output gate_driver_mode_pkg::mode_t mode_o,
    output logic buck_en_o,
    output logic charge_pump_en_o,
    output logic gate_ldo_en_o,
    output logic standby_ldo_en_o,
    output logic logic_supply_ldo_en_o,
    output logic logic_supply_ldo_lowpwr_o,
    output logic gate_out_en_o,
    output logic [gate_driver_mode_pkg::NUM_PHASES-1:0] gate_high_o,
    output logic [gate_driver_mode_pkg::NUM_PHASES-1:0] gate_low_o,
    output logic ctrl_reg_rst_o,
    output logic fault_report_n_o,
    output logic [gate_driver_mode_pkg::NUM_FAULTS-1:0] fault_status_o
);
    import gate_driver_mode_pkg::*;

    // ==========================================================
    // states
    // ==========================================================
    // wait states apply the new power set but hold the old mode while supplies settle
    typedef enum logic [3:0] {
        ST_SHUTDOWN,
        ST_STARTUP,
        ST_SLEEP,
        ST_WAKE,
        ST_OPER,
        ST_SLEEP_ENTRY,
        ST_FAULT,
        ST_FAULT_REC,
        ST_FAULT_EXIT,
        ST_SHUT_ENTRY
    } state_t;

    state_t state_reg, state_next;
    logic shut_src_reg;
    logic timer_done;
    logic [DLY_W-1:0] dwell_reg;

    function automatic logic is_wait(input state_t s);
        return s inside {ST_STARTUP, ST_WAKE, ST_SLEEP_ENTRY, ST_FAULT_REC,
                         ST_FAULT_EXIT, ST_SHUT_ENTRY};
    endfunction
    function automatic logic [DLY_W-1:0] delay_for(input state_t s);
        case (s)
            ST_STARTUP: return DLY_W'(STARTUP_DLY);
            ST_WAKE: return DLY_W'(WAKE_DLY);
            ST_SLEEP_ENTRY: return DLY_W'(SLEEP_DLY);
            ST_SHUT_ENTRY: return DLY_W'(SHUTDOWN_DLY);
            default: return DLY_W'(RECOVER_DLY);
        endcase
    endfunction
    function automatic logic is_active(input state_t s);
        return s inside {ST_OPER, ST_SLEEP_ENTRY, ST_FAULT, ST_FAULT_REC,
                         ST_FAULT_EXIT};
    endfunction

    // ==========================================================
    // decode
    // ==========================================================
    wire any_fault_w = |fault_i;
    wire in_shut_w = state_reg inside {ST_SHUTDOWN, ST_SHUT_ENTRY};
    wire go_shut_w = rail_por_fall_i && !in_shut_w;
    wire timer_load_w = (state_next != state_reg) && is_wait(state_next);

    // a fault that is not active asks for nothing, so it reads as all ones
    logic [NUM_BLK-1:0] blk_dis_n;
    always_comb
    begin
        blk_dis_n = '1;
        for (int f = 0; f < NUM_FAULTS; f++)
        begin
            if (fault_i[f])
                blk_dis_n = blk_dis_n & fault_blk_dis_n_i[f*NUM_BLK +: NUM_BLK];
        end
    end
    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        state_next = state_reg;
        if (go_shut_w)
            state_next = ST_SHUT_ENTRY;
        else
        begin
            case (state_reg)
                ST_SHUTDOWN:
                    if (rail_por_rise_i && !rail_por_fall_i)
                        state_next = ST_STARTUP;
                ST_STARTUP:
                    if (timer_done)
                        state_next = ST_SLEEP;
                ST_SLEEP:
                    if (enable_i)
                        state_next = ST_WAKE;
                ST_WAKE:
                    if (timer_done)
                        state_next = ST_OPER;
                ST_OPER:
                    if (any_fault_w)
                        state_next = ST_FAULT;
                    else if (!enable_i)
                        state_next = ST_SLEEP_ENTRY;
                ST_SLEEP_ENTRY:
                    if (timer_done)
                        state_next = ST_SLEEP;
                ST_FAULT:
                    if (!enable_i)
                        state_next = ST_FAULT_EXIT;
                    else if (!any_fault_w && recovery_done_i)
                        state_next = ST_FAULT_REC;
                ST_FAULT_REC:
                    if (any_fault_w)
                        state_next = ST_FAULT;
                    else if (timer_done)
                        state_next = ST_OPER;
                ST_FAULT_EXIT:
                    if (timer_done)
                        state_next = ST_SLEEP;
                ST_SHUT_ENTRY:
                    if (timer_done)
                        state_next = ST_SHUTDOWN;
                default:
                    state_next = ST_SHUTDOWN;
            endcase
        end
    end
    // ==========================================================
    // output decode from the state being entered
    // ==========================================================
    wire low_set_w = state_next inside {ST_SHUTDOWN, ST_STARTUP, ST_SLEEP,
                                        ST_SLEEP_ENTRY, ST_FAULT_EXIT,
                                        ST_SHUT_ENTRY};
    wire full_set_w = state_next inside {ST_WAKE, ST_OPER, ST_FAULT_REC};
    wire flt_set_w = (state_next == ST_FAULT);
    wire buck_next = full_set_w || (flt_set_w && blk_dis_n[BLK_BUCK]);
    wire cp_next = full_set_w || (flt_set_w && blk_dis_n[BLK_CP]);
    wire gldo_next = full_set_w || (flt_set_w && blk_dis_n[BLK_GATE_LDO]);
    wire drv_next = (state_next == ST_OPER)
                    || (flt_set_w && blk_dis_n[BLK_DRIVER]);
    wire lowpwr_next = low_set_w || !enable_i;
    wire rst_next = ((state_reg inside {ST_SLEEP_ENTRY, ST_FAULT_EXIT})
                     && state_next == ST_SLEEP)
                    || (state_reg == ST_SHUT_ENTRY && state_next == ST_SHUTDOWN
                        && shut_src_reg);

    mode_t mode_next;
    always_comb
    begin
        case (state_next)
            ST_SHUTDOWN, ST_STARTUP: mode_next = MODE_SHUTDOWN;
            ST_SLEEP, ST_WAKE: mode_next = MODE_SLEEP;
            ST_OPER, ST_SLEEP_ENTRY: mode_next = MODE_OPERATING;
            ST_FAULT, ST_FAULT_REC, ST_FAULT_EXIT: mode_next = MODE_FAULT;
            default: mode_next = mode_o;
        endcase
    end
    // ==========================================================
    // delay timer
    // ==========================================================
    mode_delay_timer #(
        .W(DLY_W)
    ) u_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(timer_load_w),
        .count_i(delay_for(state_next)),
        .done_o(timer_done)
    );
    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= ST_SHUTDOWN;
            shut_src_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (go_shut_w)
                shut_src_reg <= is_active(state_reg);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            mode_o <= MODE_SHUTDOWN;
            buck_en_o <= 1'b0;
            charge_pump_en_o <= 1'b0;
            gate_ldo_en_o <= 1'b0;
            standby_ldo_en_o <= 1'b1;
            logic_supply_ldo_en_o <= 1'b1;
            logic_supply_ldo_lowpwr_o <= 1'b1;
            gate_out_en_o <= 1'b0;
            gate_high_o <= '0;
            gate_low_o <= '0;
            ctrl_reg_rst_o <= 1'b0;
        end
        else
        begin
            mode_o <= mode_next;
            buck_en_o <= buck_next;
            charge_pump_en_o <= cp_next;
            gate_ldo_en_o <= gldo_next;
            standby_ldo_en_o <= !(full_set_w || flt_set_w);
            logic_supply_ldo_en_o <= 1'b1;
            logic_supply_ldo_lowpwr_o <= lowpwr_next;
            gate_out_en_o <= drv_next;
            gate_high_o <= drv_next ? high_side_ctrl_i : '0;
            gate_low_o <= drv_next ? low_side_ctrl_i : '0;
            ctrl_reg_rst_o <= rst_next;
        end
    end

    // the pin and status stay quiet in Shutdown and shutdown entry, where in_shut_w masks the faults
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            fault_report_n_o <= 1'b1;
            fault_status_o <= '0;
        end
        else
        begin
            fault_report_n_o <= !(any_fault_w && !in_shut_w);
            fault_status_o <= in_shut_w ? '0 : fault_i;
        end
    end
    // ==========================================================
    // checks
    // ==========================================================
    always_ff @(posedge clk_i)
    begin
        if (srst_i || state_next != state_reg)
            dwell_reg <= '0;
        else if (dwell_reg != '1)
            dwell_reg <= dwell_reg + DLY_W'(1);
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_rail_low_shut;
        rail_por_fall_i |=> state_reg inside {ST_SHUTDOWN, ST_SHUT_ENTRY};
    endproperty
    a_rail_low_shut: assert property (p_rail_low_shut)
        else $error("low rail did not lead to shutdown");
    property p_shut_outputs;
        mode_o == MODE_SHUTDOWN |-> standby_ldo_en_o && logic_supply_ldo_lowpwr_o
            && !buck_en_o && !charge_pump_en_o && !gate_ldo_en_o && !gate_out_en_o;
    endproperty
    a_shut_outputs: assert property (p_shut_outputs)
        else $error("shutdown power set wrong");
    property p_sleep_outputs;
        $past(state_next == ST_SLEEP) |-> !gate_out_en_o && gate_high_o == '0
            && gate_low_o == '0 && !buck_en_o && !charge_pump_en_o && !gate_ldo_en_o
            && standby_ldo_en_o && logic_supply_ldo_lowpwr_o;
    endproperty
    a_sleep_outputs: assert property (p_sleep_outputs)
        else $error("sleep outputs wrong");
    property p_oper_drive;
        state_reg == ST_OPER && $past(state_reg) == ST_OPER |-> buck_en_o
            && gate_ldo_en_o && !standby_ldo_en_o
            && gate_high_o == $past(high_side_ctrl_i);
    endproperty
    a_oper_drive: assert property (p_oper_drive)
        else $error("operating outputs wrong");
    property p_wake_len;
        state_reg == ST_WAKE && state_next == ST_OPER |-> dwell_reg == DLY_W'(WAKE_DLY);
    endproperty
    a_wake_len: assert property (p_wake_len)
        else $error("wake delay length wrong");
    property p_sleep_entry;
        state_reg == ST_OPER && !enable_i && !any_fault_w && !rail_por_fall_i
            |=> state_reg == ST_SLEEP_ENTRY ##0 logic_supply_ldo_lowpwr_o;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep entry not taken");
    property p_fault_entry;
        state_reg inside {ST_OPER, ST_FAULT} && any_fault_w && enable_i
            && !rail_por_fall_i |=> state_reg == ST_FAULT;
    endproperty
    a_fault_entry: assert property (p_fault_entry)
        else $error("fault did not hold fault mode");
    property p_fault_and;
        state_reg == ST_FAULT && $past(state_next) == ST_FAULT
            |-> buck_en_o == $past(blk_dis_n[BLK_BUCK]);
    endproperty
    a_fault_and: assert property (p_fault_and)
        else $error("fault disable requests not combined");
    property p_ctrl_reset;
        state_reg == ST_SLEEP_ENTRY && state_next == ST_SLEEP |=> ctrl_reg_rst_o;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset)
        else $error("control reset missing");
    property p_report;
        state_reg == ST_FAULT && any_fault_w |=> !fault_report_n_o;
    endproperty
    a_report: assert property (p_report)
        else $error("fault not reported");
    property p_recover_len;
        state_reg inside {ST_FAULT_REC, ST_FAULT_EXIT} && state_next != state_reg
            && !rail_por_fall_i && !any_fault_w |-> dwell_reg == DLY_W'(RECOVER_DLY);
    endproperty
    a_recover_len: assert property (p_recover_len)
        else $error("recovery delay length wrong");
    property p_startup;
        state_reg == ST_SHUTDOWN && rail_por_rise_i && !rail_por_fall_i
            |=> state_reg == ST_STARTUP;
    endproperty
    a_startup: assert property (p_startup)
        else $error("start-up not begun");

    c_wake: cover property (state_reg == ST_WAKE ##1 state_reg == ST_OPER);
    c_fault: cover property (state_reg == ST_FAULT_REC ##1 state_reg == ST_OPER);
    c_exit: cover property (state_reg == ST_FAULT_EXIT ##1 state_reg == ST_SLEEP);
    c_shut: cover property (ctrl_reg_rst_o && mode_o == MODE_SHUTDOWN);

endmodule // gate_driver_mode_fsm

// ---- gate_driver_mode_pkg.sv ----
// constants and types shared by the gate driver mode sequencer
package gate_driver_mode_pkg;

    // ==========================================================
    // clock and delay timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    // longest sleep-entry delay; a longest time rounds down
    localparam int T_SLEEP_MAX_NS = 850000;
    localparam int SLEEP_CYC = T_SLEEP_MAX_NS / CLK_PERIOD_NS;
    // plain defaults for delays whose figures are not fixed
    localparam int T_STARTUP_NS = 640;
    localparam int STARTUP_CYC = (T_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WAKE_NS = 2000;
    localparam int WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_SHUTDOWN_NS = 320;
    localparam int SHUTDOWN_CYC = (T_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RECOVER_NS = 1000;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 17;

    // ==========================================================
    // fault sources (bit positions of the fault vector)
    // ==========================================================
    localparam int NUM_FAULTS = 9;
    localparam int FLT_VM_UV = 0;
    localparam int FLT_VM_OV = 1;
    localparam int FLT_CP_UV = 2;
    localparam int FLT_VDS_OCP = 3;
    localparam int FLT_CS_OCP = 4;
    localparam int FLT_VGS = 5;
    localparam int FLT_TWARN = 6;
    localparam int FLT_TSD = 7;
    localparam int FLT_BUCK = 8;

    // ==========================================================
    // function blocks that a fault may disable
    // ==========================================================
    localparam int NUM_BLK = 4;
    localparam int BLK_BUCK = 0;
    localparam int BLK_CP = 1;
    localparam int BLK_GATE_LDO = 2;
    localparam int BLK_DRIVER = 3;
    localparam int NUM_PHASES = 3;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN,
        MODE_SLEEP,
        MODE_OPERATING,
        MODE_FAULT
    } mode_t;

endpackage

// ---- mode_delay_timer.sv ----
// one-shot down counter that times the mode transition delays
`timescale 1ns/100ps
module mode_delay_timer #(
    parameter int W = 17
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic done_o
);
    logic [W-1:0] cnt_reg;
    logic run_reg;
    logic done_reg;
    wire last_w = run_reg && (cnt_reg <= W'(1));

    // done rises count_i cycles after the load edge; a reload restarts it
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= last_w && !load_i;
            if (load_i)
            begin
                cnt_reg <= count_i;
                run_reg <= 1'b1;
            end
            else if (last_w)
                run_reg <= 1'b0;
            else if (run_reg)
                cnt_reg <= cnt_reg - W'(1);
        end
    end

    assign done_o = done_reg;
endmodule // mode_delay_timer

// ---- host_enable_model.sv ----
// host side model that drives the gate driver enable line
`timescale 1ns/100ps
module host_enable_model #(
    parameter int MIN_LOW = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    output logic enable_o
);
    // ==========================================================
    // enable line with an enforced minimum low time
    // ==========================================================
    int low_cnt;
    // a short low pulse leaves the device undefined, so a new rise waits out the count
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            enable_o <= 1'b0;
            low_cnt <= 0;
        end
        else if (enable_o && !run_i)
        begin
            enable_o <= 1'b0;
            low_cnt <= MIN_LOW;
        end
        else if (!enable_o && low_cnt != 0)
            low_cnt <= low_cnt - 1;
        else if (!enable_o && run_i)
            enable_o <= 1'b1;
    end
endmodule // host_enable_model

// ---- gate_driver_mode_fsm_test.sv ----
// self-checking testbench for the gate driver mode state machine
`timescale 1ns/100ps
module gate_driver_mode_fsm_test;
    import gate_driver_mode_pkg::*;
    localparam int SLP = 6;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic rise = 1'b0;
    logic fall = 1'b1;
    logic run = 1'b0;
    logic en;
    logic [NUM_FAULTS-1:0] flt = '0;
    logic [NUM_FAULTS*NUM_BLK-1:0] dis_n = '1;
    logic rec_done = 1'b0;
    logic [NUM_PHASES-1:0] hs = 3'h5;
    logic [NUM_PHASES-1:0] ls = 3'h2;
    mode_t mode;
    logic buck, cp, gldo, sby, lgen, lowpwr, goe, crst, frep_n;
    logic [NUM_PHASES-1:0] gh, gl;
    logic [NUM_FAULTS-1:0] fstat;
    int n_errors = 0;
    int compares = 0;

    initial forever #5 clk_i = ~clk_i;

    host_enable_model #(.MIN_LOW(SLP)) host (.clk_i(clk_i), .srst_i(srst_i), .run_i(run),
        .enable_o(en));
    gate_driver_mode_fsm #(.STARTUP_DLY(4), .WAKE_DLY(8), .SLEEP_DLY(SLP), .SHUTDOWN_DLY(3),
        .RECOVER_DLY(4)) DUT (.clk_i(clk_i), .srst_i(srst_i), .rail_por_rise_i(rise),
        .rail_por_fall_i(fall), .enable_i(en), .fault_i(flt), .fault_blk_dis_n_i(dis_n),
        .recovery_done_i(rec_done), .high_side_ctrl_i(hs), .low_side_ctrl_i(ls),
        .mode_o(mode), .buck_en_o(buck), .charge_pump_en_o(cp), .gate_ldo_en_o(gldo),
        .standby_ldo_en_o(sby), .logic_supply_ldo_en_o(lgen),
        .logic_supply_ldo_lowpwr_o(lowpwr), .gate_out_en_o(goe), .gate_high_o(gh),
        .gate_low_o(gl), .ctrl_reg_rst_o(crst), .fault_report_n_o(frep_n),
        .fault_status_o(fstat));

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_mode(input mode_t exp);
        chk(16'(mode), 16'(exp));
    endtask

    // bounded wait; running out of cycles ends the run
    task automatic wait_mode(input mode_t m);
        int i;
        for (i = 0; i < 60 && mode !== m; i++)
            tick(1);
        chk_mode(m);
        if (mode !== m)
            summarize();
    endtask

    // power set packed as buck, cp, gate ldo, standby, logic en, low power, gate enable
    function automatic logic [15:0] pwr();
        return {9'h0, buck, cp, gldo, sby, lgen, lowpwr, goe};
    endfunction

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_power_up();
        chk_mode(MODE_SHUTDOWN);
        chk(pwr(), 16'h000e);
        @(posedge clk_i);
        fall <= 1'b0;
        rise <= 1'b1;
        tick(1);
        chk_mode(MODE_SHUTDOWN);
        wait_mode(MODE_SLEEP);
        chk(pwr(), 16'h000e);
        chk({gh, gl}, 16'h0);
    endtask

    task automatic t_wake();
        @(posedge clk_i);
        run <= 1'b1;
        tick(3);
        chk(pwr(), 16'h0074);
        chk_mode(MODE_SLEEP);
        wait_mode(MODE_OPERATING);
        tick(2);
        chk(pwr(), 16'h0075);
        chk({gh, gl}, 16'h2a);
    endtask

    task automatic t_each_fault();
        int i;
        for (i = 0; i < NUM_FAULTS; i++)
        begin
            @(posedge clk_i);
            flt <= NUM_FAULTS'(1) << i;
            tick(2);
            chk_mode(MODE_FAULT);
            chk({frep_n, 6'h0, fstat}, 16'(1) << i);
            @(posedge clk_i);
            flt <= '0;
            rec_done <= 1'b1;
            wait_mode(MODE_OPERATING);
            chk(16'(frep_n), 16'h1);
            @(posedge clk_i);
            rec_done <= 1'b0;
        end
    endtask

    task automatic t_fault_and();
        @(posedge clk_i);
        dis_n[3:0] <= 4'he;
        dis_n[15:12] <= 4'hd;
        flt <= 9'h001;
        tick(2);
        chk({13'h0, gldo, cp, buck}, 16'h6);
        @(posedge clk_i);
        flt <= 9'h009;
        tick(2);
        chk_mode(MODE_FAULT);
        chk({13'h0, gldo, cp, buck}, 16'h4);
        @(posedge clk_i);
        run <= 1'b0;
        tick(2);
        chk(16'(lowpwr), 16'h1);
        wait_mode(MODE_SLEEP);
        chk(16'(crst), 16'h1);
        @(posedge clk_i);
        flt <= '0;
        dis_n <= '1;
    endtask

    task automatic t_sleep_entry();
        @(posedge clk_i);
        run <= 1'b1;
        wait_mode(MODE_OPERATING);
        @(posedge clk_i);
        run <= 1'b0;
        tick(3);
        chk(pwr(), 16'h000e);
        chk_mode(MODE_OPERATING);
        wait_mode(MODE_SLEEP);
        chk(16'(crst), 16'h1);
        tick(1);
        chk(16'(crst), 16'h0);
    endtask

    task automatic t_rail_fall();
        @(posedge clk_i);
        run <= 1'b1;
        wait_mode(MODE_OPERATING);
        @(posedge clk_i);
        rise <= 1'b0;
        fall <= 1'b1;
        wait_mode(MODE_SHUTDOWN);
        chk(16'(crst), 16'h1);
        chk(16'({buck, cp, gldo, sby, lgen, goe}), 16'h06);
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        tick(1);
        t_power_up();
        t_wake();
        t_each_fault();
        t_fault_and();
        t_sleep_entry();
        t_rail_fall();
        summarize();
    end
endmodule // gate_driver_mode_fsm_test
